/* File: pbwc_wait_ctrl.sv */
/*
 * CPU side wait insertion for accesses to the asynchronous peripheral bus.
 * Assumes the CPU pulses one access request at a time and waits for ack,
 * and the peripheral side drives a busy level and read data, both from its
 * own unrelated clock.
 */
`timescale 1ns/1ps
`include "pbwc_defines.svh"

// Summary of operation
// R1 - Peripheral bus asynchronous; conflicting data untrusted
// R2 - Repeat conflicting access until data valid
// R3 - Stall next instruction during the wait
// R4 - Execution grows by exactly inserted wait clocks
// R5 - Only serial status reads wait, one clock
// R6 - Peripheral wait request synchronised before stalling
module pbwc_wait_ctrl (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic acc_req,
    input wire pbwc_pkg::pbwc_access_s acc,
    input wire logic periph_busy,
    input wire logic [`PBWC_DATA_W-1:0] periph_rdata,
    output logic cpu_stall,
    output logic acc_ack,
    output logic [`PBWC_DATA_W-1:0] acc_rdata,
    output logic [`PBWC_CNT_W-1:0] wait_clks
);

    // ------------------------------------------------------------------------
    // Synchronisation of peripheral side signals
    // ------------------------------------------------------------------------
    logic [`PBWC_SYNC_W-1:0] sync_bus;
    logic busy_s;
    logic [`PBWC_DATA_W-1:0] rdata_s;

    pbwc_sync3 u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .async_in({periph_busy, periph_rdata}),
        .sync_out(sync_bus)
    ); // [R1] [R6]

    // Data bits cross on their own; serial status reads trust them only behind a low busy
    assign busy_s = sync_bus[`PBWC_SYNC_W-1];
    assign rdata_s = sync_bus[`PBWC_DATA_W-1:0];

    // ------------------------------------------------------------------------
    // Decode of accesses that raise a wait request
    // ------------------------------------------------------------------------
    // Writes and all other targets complete without a wait
    logic needs_wait;

    always_comb
    begin
        needs_wait = acc.rd && ((acc.target == `PBWC_TGT_SERIAL0_RX_STATUS) ||
                                (acc.target == `PBWC_TGT_SERIAL1_RX_STATUS)); // [R5]
    end

    // ------------------------------------------------------------------------
    // Wait sequencer events
    // ------------------------------------------------------------------------
    pbwc_pkg::pbwc_state_e state_q;
    pbwc_pkg::pbwc_state_e state_d;
    logic [`PBWC_CNT_W-1:0] cnt_q;
    logic [`PBWC_CNT_W-1:0] cnt_d;
    logic take_wait;
    logic take_plain;
    logic retry_due;
    logic retry_busy;
    logic retry_done;

    // Requests in the wait state are dropped; the CPU has no second slot
    always_comb
    begin
        take_wait = 1'b0;
        take_plain = 1'b0;
        retry_due = 1'b0;
        unique case (state_q)
            pbwc_pkg::PBWC_IDLE:
            begin
                take_wait = acc_req && needs_wait; // [R5]
                take_plain = acc_req && !needs_wait;
            end
            pbwc_pkg::PBWC_WAIT:
            begin
                retry_due = (cnt_q == 8'h01);
            end
        endcase
        // Conflict seen at retry; access is repeated
        retry_busy = retry_due && busy_s; // [R2]
        retry_done = retry_due && !busy_s; // [R2]
    end

    // ------------------------------------------------------------------------
    // Sequencer state and retry counter
    // ------------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        if (take_wait)
        begin
            // Pipeline held off before the first returned value is used
            state_d = pbwc_pkg::PBWC_WAIT;
            cnt_d = `PBWC_WAIT_SERIAL_RX; // [R5]
        end
        else if (retry_busy)
        begin
            // Reload rather than count on; each repetition costs one more clock
            cnt_d = `PBWC_WAIT_SERIAL_RX; // [R2]
        end
        else if (retry_done)
        begin
            state_d = pbwc_pkg::PBWC_IDLE;
            cnt_d = '0;
        end
        else if (state_q == pbwc_pkg::PBWC_WAIT)
        begin
            cnt_d = cnt_q - 8'h01;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            state_q <= pbwc_pkg::PBWC_IDLE;
            cnt_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // ------------------------------------------------------------------------
    // Wait clock count
    // ------------------------------------------------------------------------
    logic [`PBWC_CNT_W-1:0] wait_clks_q;
    logic [`PBWC_CNT_W-1:0] wait_clks_d;

    // One count per clock in the wait state, retries included; wraps past all ones
    always_comb
    begin
        wait_clks_d = wait_clks_q;
        if (take_wait || take_plain)
        begin
            wait_clks_d = '0;
        end
        else if (state_q == pbwc_pkg::PBWC_WAIT)
        begin
            wait_clks_d = wait_clks_q + 8'h01; // [R4]
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            wait_clks_q <= '0;
        end
        else
        begin
            wait_clks_q <= wait_clks_d;
        end
    end

    // ------------------------------------------------------------------------
    // Stall, acknowledge and read data
    // ------------------------------------------------------------------------
    logic stall_q;
    logic stall_d;
    logic ack_q;
    logic ack_d;
    logic [`PBWC_DATA_W-1:0] rdata_q;
    logic [`PBWC_DATA_W-1:0] rdata_d;

    // Data taken on a plain access, or at the retry when the synchronised busy level is low
    always_comb
    begin
        stall_d = stall_q;
        ack_d = 1'b0;
        rdata_d = rdata_q;
        if (take_wait)
        begin
            stall_d = 1'b1; // [R3]
        end
        else if (take_plain || retry_done)
        begin
            stall_d = 1'b0; // [R3]
            ack_d = 1'b1;
            rdata_d = rdata_s; // [R2]
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!reset_n)
        begin
            stall_q <= 1'b0;
            ack_q <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            stall_q <= stall_d;
            ack_q <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------------------
    assign cpu_stall = stall_q;
    assign acc_ack = ack_q;
    assign acc_rdata = rdata_q;
    assign wait_clks = wait_clks_q;

endmodule : pbwc_wait_ctrl

/* File: pbwc_defines.svh */
/*
 * Constants of the peripheral bus wait control block: widths, wait counts,
 * target codes.
 * Assumes inclusion by bare name from the package and from the design modules.
 */
`ifndef PBWC_DEFINES_SVH
`define PBWC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------------
`define PBWC_DATA_W 8
`define PBWC_CNT_W 8
`define PBWC_SYNC_W 9

// ----------------------------------------------------------------------------
// Wait clocks per access type
// ----------------------------------------------------------------------------
`define PBWC_WAIT_SERIAL_RX 8'h01

// ----------------------------------------------------------------------------
// Target codes, CPU side decode
// ----------------------------------------------------------------------------
`define PBWC_TGT_NONE 2'h0
`define PBWC_TGT_SERIAL0_RX_STATUS 2'h1
`define PBWC_TGT_SERIAL1_RX_STATUS 2'h2
`define PBWC_TGT_OTHER 2'h3

`endif

/* File: pbwc_pkg.sv */
/*
 * Types of the peripheral bus wait control block.
 * Assumes pbwc_defines.svh is on the include path.
 */
`include "pbwc_defines.svh"

package pbwc_pkg;

    // ------------------------------------------------------------------------
    // Access carrier
    // ------------------------------------------------------------------------
    typedef logic [1:0] pbwc_target_t;

    typedef struct packed {
        logic rd;
        pbwc_target_t target;
    } pbwc_access_s;

    typedef enum logic [1:0] {
        PBWC_IDLE = 2'b01,
        PBWC_WAIT = 2'b10
    } pbwc_state_e;

endpackage : pbwc_pkg

/* File: pbwc_sync3.sv */
/*
 * Three-stage input synchroniser; a bit changes once stages two and three agree.
 * Assumes asynchronous inputs and sys_clk as the sampling clock.
 */
`timescale 1ns/1ps
`include "pbwc_defines.svh"

module pbwc_sync3 (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [`PBWC_SYNC_W-1:0] async_in,
    output logic [`PBWC_SYNC_W-1:0] sync_out
);

    // ------------------------------------------------------------------------
    // Per-bit stages
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `PBWC_SYNC_W; gi = gi + 1)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic out_q;
            logic out_d;

            always_comb
            begin
                out_d = (s2_q == s3_q) ? s3_q : out_q;
            end

            // First stage feeds only the second; metastability stays contained
            always_ff @(posedge sys_clk)
            begin
                if (!reset_n)
                begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    out_q <= 1'b0;
                end
                else
                begin
                    s1_q <= async_in[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    out_q <= out_d;
                end
            end

            assign sync_out[gi] = out_q;
        end
    endgenerate

endmodule : pbwc_sync3

/* File: pbwc_props.sv */
/* Port checker for pbwc_wait_ctrl.
   Assumes one clock domain and a synchronous active-low reset. */
`timescale 1ns/1ps
`include "pbwc_defines.svh"
module pbwc_props (
    input logic sys_clk,
    input logic reset_n,
    input logic acc_req,
    input pbwc_pkg::pbwc_access_s acc,
    input logic periph_busy,
    input logic [`PBWC_DATA_W-1:0] periph_rdata,
    input logic cpu_stall,
    input logic acc_ack,
    input logic [`PBWC_DATA_W-1:0] acc_rdata,
    input logic [`PBWC_CNT_W-1:0] wait_clks
);
    logic [`PBWC_CNT_W-1:0] stall_cnt_q, stall_cnt_d;
    logic wait_rd;
    assign wait_rd = acc_req && !cpu_stall && acc.rd && (acc.target == 2'h1 || acc.target == 2'h2);
    always_comb stall_cnt_d = cpu_stall ? stall_cnt_q + 8'h01 : 8'h00;
    always_ff @(posedge sys_clk) stall_cnt_q <= reset_n ? stall_cnt_d : 8'h00;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    // Six quiet cycles cover the synchroniser latency
    sequence quiet_s; (!periph_busy)[*6]; endsequence
    chk_serial_stalls: assert property (wait_rd |=> cpu_stall)
        else $error("serial read did not stall");
    chk_plain_nowait: assert property (acc_req && !cpu_stall && !wait_rd |=> acc_ack && !cpu_stall && wait_clks == 8'h00)
        else $error("plain access waited");
    chk_end_acks: assert property ($fell(cpu_stall) |-> acc_ack)
        else $error("stall ended without ack");
    chk_wait_count: assert property (acc_ack && $past(cpu_stall) |-> wait_clks == stall_cnt_q)
        else $error("wait count wrong");
    chk_one_clock: assert property (quiet_s ##0 cpu_stall |=> !cpu_stall)
        else $error("quiet wait not one clock");
    chk_busy_holds: assert property (periph_busy[*6] ##0 acc_ack |-> wait_clks == 8'h00)
        else $error("read acked while busy");
endmodule : pbwc_props
bind pbwc_wait_ctrl pbwc_props i_props (.sys_clk(sys_clk), .reset_n(reset_n), .acc_req(acc_req), .acc(acc),
    .periph_busy(periph_busy), .periph_rdata(periph_rdata), .cpu_stall(cpu_stall), .acc_ack(acc_ack),
    .acc_rdata(acc_rdata), .wait_clks(wait_clks));

/* File: pbwc_periph_model.sv */
/* Peripheral register side: busy level and read data on its own clock.
   Assumes the bench sets the wanted busy level and data. */
`timescale 1ns/1ps
`include "pbwc_defines.svh"
module pbwc_periph_model (
    input logic busy_set,
    input logic [`PBWC_DATA_W-1:0] data_set,
    output logic periph_busy,
    output logic [`PBWC_DATA_W-1:0] periph_rdata
);
    logic pclk = 1'b0;
    // Unrelated rate, so edges drift against the CPU clock
    initial forever #37 pclk = ~pclk;
    always @(posedge pclk)
    begin
        periph_busy <= busy_set;
        periph_rdata <= busy_set ? ~periph_rdata : data_set;
    end
endmodule : pbwc_periph_model

/* File: tb.sv */
/* Self-checking bench for pbwc_wait_ctrl.
   Assumes the checker is bound in and the peripheral model is compiled. */
`timescale 1ns/1ps
`include "pbwc_defines.svh"
`define CHK(n, e, v) begin checks++; if ((v) !== (e)) begin failures++; \
    $display("BAD %s expected %0h seen %0h", n, e, v); end end
module tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic acc_req = 1'b0;
    pbwc_pkg::pbwc_access_s acc = '0;
    logic busy_set = 1'b0;
    logic [7:0] data_set = 8'h00;
    logic periph_busy, cpu_stall, acc_ack;
    logic [7:0] periph_rdata, acc_rdata, wait_clks;
    int failures = 0;
    int checks = 0;
    pbwc_wait_ctrl i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .acc_req(acc_req), .acc(acc),
        .periph_busy(periph_busy), .periph_rdata(periph_rdata), .cpu_stall(cpu_stall),
        .acc_ack(acc_ack), .acc_rdata(acc_rdata), .wait_clks(wait_clks));
    pbwc_periph_model i_periph (.busy_set(busy_set), .data_set(data_set), .periph_busy(periph_busy),
        .periph_rdata(periph_rdata));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic go(input logic rd, input logic [1:0] tgt);
        @(negedge sys_clk);
        acc_req = 1'b1;
        acc = {rd, tgt};
        @(negedge sys_clk);
        acc_req = 1'b0;
    endtask : go
    task automatic t_nowait;
        data_set = 8'h5A;
        repeat (8) @(negedge sys_clk);
        for (int i = 0; i < 8; i++)
            if (!(i[2] && (i[1] ^ i[0])))
            begin
                go(i[2], i[1:0]);
                `CHK("ack", 1'b1, acc_ack)
                `CHK("waits", 8'h00, wait_clks)
                if (i[2]) `CHK("plain rdata", 8'h5A, acc_rdata)
            end
        $display("t_nowait done");
    endtask : t_nowait
    task automatic t_serial;
        for (int i = 1; i < 3; i++)
        begin
            data_set = 8'h3C ^ i[7:0];
            repeat (8) @(negedge sys_clk);
            go(1'b1, i[1:0]);
            `CHK("stall", 1'b1, cpu_stall)
            @(negedge sys_clk);
            `CHK("ack", 1'b1, acc_ack)
            `CHK("rdata", data_set, acc_rdata)
            `CHK("waits", 8'h01, wait_clks)
        end
        $display("t_serial done");
    endtask : t_serial
    task automatic t_busy;
        int n;
        busy_set = 1'b1;
        data_set = 8'hC3;
        repeat (8) @(negedge sys_clk);
        go(1'b0, 2'h3);
        `CHK("busy write", 8'h00, wait_clks)
        go(1'b1, 2'h2);
        n = 1;
        // Second request mid-stall must be dropped
        repeat (6)
        begin
            @(negedge sys_clk);
            n += cpu_stall;
            acc_req = (n == 2);
        end
        busy_set = 1'b0;
        while (acc_ack !== 1'b1 && n < 40)
        begin
            @(negedge sys_clk);
            n += cpu_stall;
        end
        `CHK("rdata", 8'hC3, acc_rdata)
        `CHK("waits", n[7:0], wait_clks)
        `CHK("long", 1'b1, n > 6)
        @(negedge sys_clk);
        `CHK("extra ack", 1'b0, acc_ack)
        $display("t_busy done");
    endtask : t_busy
    task automatic t_reset;
        busy_set = 1'b1;
        repeat (8) @(negedge sys_clk);
        go(1'b1, 2'h1);
        // Reset in mid-wait drops the access without an ack
        reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        `CHK("reset stall", 1'b0, cpu_stall)
        `CHK("reset waits", 8'h00, wait_clks)
        `CHK("reset rdata", 8'h00, acc_rdata)
        reset_n = 1'b1;
        busy_set = 1'b0;
        @(negedge sys_clk);
        `CHK("reset ack", 1'b0, acc_ack)
        repeat (8) @(negedge sys_clk);
        go(1'b1, 2'h1);
        @(negedge sys_clk);
        `CHK("first ack", 1'b1, acc_ack)
        `CHK("first rdata", 8'hC3, acc_rdata)
        // Next access given in the cycle of the ack
        acc_req = 1'b1;
        acc = {1'b0, 2'h3};
        @(negedge sys_clk);
        acc_req = 1'b0;
        `CHK("second ack", 1'b1, acc_ack)
        `CHK("second waits", 8'h00, wait_clks)
        $display("t_reset done");
    endtask : t_reset
    initial
    begin
        repeat (20) @(negedge sys_clk);
        reset_n = 1'b1;
        t_nowait();
        t_serial();
        t_busy();
        t_reset();
        test_done();
    end
    initial
    begin
        repeat (2000) @(posedge sys_clk);
        failures++;
        test_done();
    end
endmodule : tb
